// File: rtl/tmr_ctl_regs.svh
// register offsets, field positions and reset values of the timer control block
`ifndef TMR_CTL_REGS_SVH
`define TMR_CTL_REGS_SVH
`define CTL_ONE_OFFS 12'h000
`define CTL_TWO_OFFS 12'h004
`define EVGEN_OFFS 12'h014
`define IRQ_STAT_OFFS 12'h040
`define IRQ_MASK_OFFS 12'h044
`define BIT_RUN_EN 0
`define BIT_UPD_SUPP 1
`define BIT_UPD_SRC 2
`define BIT_SINGLE 3
`define BIT_MS_SYNC 4
`define SLAVE_MODE_LSB 5
`define MMS_LSB 4
`define BIT_IN1_SEL 7
`define BIT_SW_UPD 0
`define CTL_ONE_RESET 8'h00
`define CTL_TWO_RESET 8'h00
`define CTL_ONE_MASK 8'h7F
`define CTL_TWO_MASK 8'hF0
`define IRQ_UPDATE 0
`define IRQ_TRIGGER 1
`endif

// File: rtl/tmr_ctl_pkg.sv
// types of the timer update and master trigger control block
package tmr_ctl_pkg;
    typedef enum logic [2:0] {
        MM_RESET = 3'h0, MM_ENABLE = 3'h1, MM_UPDATE = 3'h2, MM_PULSE = 3'h3,
        MM_REF1 = 3'h4, MM_REF3 = 3'h5, MM_REF2 = 3'h6, MM_REF4 = 3'h7
    } master_mode_e;
    typedef enum logic [1:0] {
        SM_OFF = 2'h0, SM_RESET = 2'h1, SM_GATED = 2'h2, SM_TRIGGER = 2'h3
    } slave_mode_e;
    typedef enum logic [2:0] {
        AP_IDLE = 3'b001, AP_ACCESS = 3'b010, AP_DONE = 3'b100
    } apb_state_e;
    typedef struct packed {
        logic hallA;
        logic hallB;
        logic hallC;
    } hall_s;
    typedef struct packed {
        logic ref1;
        logic ref2;
        logic ref3;
        logic ref4;
    } refs_s;
    typedef struct packed {
        apb_state_e apb;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [7:0] ctlOne;
        logic [7:0] ctlTwo;
        logic [1:0] irqStat;
        logic [1:0] irqMask;
        logic irq;
        logic swUpd;
        logic trigIn1;
        logic trigIn2;
        logic trigPrev;
        logic trigDly;
        logic gateDly;
        logic updEvt;
        logic updIrqReq;
        logic shadowLoad;
        logic cntReinit;
        logic cntEnable;
        logic filterIn;
        logic trgOut;
    } state_s;
endpackage : tmr_ctl_pkg

// File: rtl/tmr_ctl.sv
// timer update-event, counter-enable and master trigger output control with APB registers
`timescale 1ns/1ps
`include "tmr_ctl_regs.svh"
module tmr_ctl
    import tmr_ctl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic triggerInput,
    input wire logic counterOverflow,
    input wire logic channelOneEvent,
    input wire refs_s refs,
    input wire logic captureInputOne,
    input wire hall_s hallSensorInputs,
    output logic filterInputOne,
    output logic counterEnableSignal,
    output logic updateEvent,
    output logic updateIrqRequest,
    output logic shadowLoad,
    output logic counterReinit,
    output logic triggerOutput,
    output logic irq
);
    state_s s_q;
    state_s s_d;

    function automatic logic [7:0] maskBits(input logic [31:0] w, input logic [7:0] m);
        maskBits = w[7:0] & m;
    endfunction : maskBits

    logic wrAcc;
    logic rdAcc;
    logic mapped;
    logic swTrig;
    logic trigEdge;
    logic trigSel;
    logic gateSel;
    logic slaveReset;
    logic updSrc;
    logic updGen;
    logic runEn;
    logic cenSig;
    slave_mode_e sMode;
    master_mode_e mMode;

    always_comb begin
        s_d = s_q;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        wrAcc = 1'b0;
        rdAcc = 1'b0;
        mapped = (paddr == `CTL_ONE_OFFS) || (paddr == `CTL_TWO_OFFS)
            || (paddr == `EVGEN_OFFS) || (paddr == `IRQ_STAT_OFFS)
            || (paddr == `IRQ_MASK_OFFS);
        unique case (s_q.apb)
            AP_IDLE: begin
                if (psel && !penable) begin
                    s_d.apb = AP_ACCESS;
                end
            end
            AP_ACCESS: begin
                s_d.apb = AP_DONE;
                s_d.pready = 1'b1;
                s_d.pslverr = !mapped;
                rdAcc = psel && !pwrite;
            end
            AP_DONE: begin
                s_d.apb = AP_IDLE;
                // write lands at the edge at which the master samples pready high
                wrAcc = psel && penable && pwrite && mapped;
            end
            default: begin
                s_d.apb = AP_IDLE;
            end
        endcase

        // trigger input crosses in from outside through two flops
        s_d.trigIn1 = triggerInput;
        s_d.trigIn2 = s_q.trigIn1;
        s_d.trigPrev = s_q.trigIn2;
        sMode = slave_mode_e'(s_q.ctlOne[`SLAVE_MODE_LSB +: 2]);
        mMode = master_mode_e'(s_q.ctlTwo[`MMS_LSB +: 3]);
        trigEdge = s_q.trigIn2 && !s_q.trigPrev;
        s_d.trigDly = trigEdge;
        trigSel = s_q.ctlOne[`BIT_MS_SYNC] ? s_q.trigDly : trigEdge;
        gateSel = s_q.ctlOne[`BIT_MS_SYNC] ? s_q.gateDly : s_q.trigIn2;
        s_d.gateDly = s_q.trigIn2;
        slaveReset = (sMode == SM_RESET) && trigSel;

        swTrig = wrAcc && (paddr == `EVGEN_OFFS) && pwdata[`BIT_SW_UPD];
        s_d.swUpd = swTrig;

        updGen = counterOverflow || swTrig || slaveReset;
        s_d.updEvt = updGen && !s_q.ctlOne[`BIT_UPD_SUPP];
        s_d.shadowLoad = updGen && !s_q.ctlOne[`BIT_UPD_SUPP];
        s_d.cntReinit = swTrig || slaveReset;
        updSrc = s_q.ctlOne[`BIT_UPD_SRC] ? counterOverflow : updGen;
        s_d.updIrqReq = updSrc && !s_q.ctlOne[`BIT_UPD_SUPP];

        runEn = s_q.ctlOne[`BIT_RUN_EN];
        if (wrAcc && paddr == `CTL_ONE_OFFS) begin
            runEn = pwdata[`BIT_RUN_EN];
            s_d.ctlOne = maskBits(pwdata, `CTL_ONE_MASK);
        end
        if (sMode == SM_TRIGGER && trigSel) begin
            runEn = 1'b1;
        end
        if (s_d.updEvt && s_q.ctlOne[`BIT_SINGLE]) begin
            runEn = 1'b0;
        end
        s_d.ctlOne[`BIT_RUN_EN] = runEn;
        if (wrAcc && paddr == `CTL_TWO_OFFS) begin
            s_d.ctlTwo = maskBits(pwdata, `CTL_TWO_MASK);
        end

        // run gating; gated mode needs run bit too
        cenSig = s_q.ctlOne[`BIT_RUN_EN] && ((sMode != SM_GATED) || gateSel);
        s_d.cntEnable = cenSig;

        s_d.filterIn = s_q.ctlTwo[`BIT_IN1_SEL]
            ? (hallSensorInputs.hallA ^ hallSensorInputs.hallB ^ hallSensorInputs.hallC)
            : captureInputOne;

        unique case (mMode)
            // reset mode: slave reset lags through sync flops
            MM_RESET: s_d.trgOut = s_q.swUpd || slaveReset;
            // enable; gated path carries its sync delay
            MM_ENABLE: s_d.trgOut = cenSig;
            MM_UPDATE: s_d.trgOut = s_d.updEvt;
            MM_PULSE: s_d.trgOut = channelOneEvent;
            MM_REF1: s_d.trgOut = refs.ref1;
            MM_REF3: s_d.trgOut = refs.ref3;
            MM_REF2: s_d.trgOut = refs.ref2;
            MM_REF4: s_d.trgOut = refs.ref4;
        endcase

        // set wins over write-one-to-clear
        if (wrAcc && paddr == `IRQ_STAT_OFFS) begin
            s_d.irqStat = s_q.irqStat & ~pwdata[1:0];
        end
        if (s_q.updIrqReq) begin
            s_d.irqStat[`IRQ_UPDATE] = 1'b1;
        end
        if (trigSel) begin
            s_d.irqStat[`IRQ_TRIGGER] = 1'b1;
        end
        if (wrAcc && paddr == `IRQ_MASK_OFFS) begin
            s_d.irqMask = pwdata[1:0];
        end
        s_d.irq = |(s_d.irqStat & s_d.irqMask);

        if (rdAcc) begin
            s_d.prdata = 32'h0;
            if (paddr == `CTL_ONE_OFFS) s_d.prdata[7:0] = s_q.ctlOne;
            if (paddr == `CTL_TWO_OFFS) s_d.prdata[7:0] = s_q.ctlTwo;
            if (paddr == `IRQ_STAT_OFFS) s_d.prdata[1:0] = s_q.irqStat;
            if (paddr == `IRQ_MASK_OFFS) s_d.prdata[1:0] = s_q.irqMask;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.apb <= AP_IDLE;
            s_q.ctlOne <= `CTL_ONE_RESET;
            s_q.ctlTwo <= `CTL_TWO_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign filterInputOne = s_q.filterIn;
    assign counterEnableSignal = s_q.cntEnable;
    assign updateEvent = s_q.updEvt;
    assign updateIrqRequest = s_q.updIrqReq;
    assign shadowLoad = s_q.shadowLoad;
    assign counterReinit = s_q.cntReinit;
    assign triggerOutput = s_q.trgOut;
    assign irq = s_q.irq;

    AST_SUPPRESS_NO_UPDATE: assert property (@(posedge clk) disable iff (!rst_n)
        $past(s_q.ctlOne[`BIT_UPD_SUPP]) |-> !updateEvent)
        else $error("update event while suppressed");
    AST_OVF_UPDATE: assert property (@(posedge clk) disable iff (!rst_n)
        counterOverflow && !s_q.ctlOne[`BIT_UPD_SUPP] |=> updateEvent && shadowLoad)
        else $error("overflow without update event");
    AST_SRC_OVF_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
        updateIrqRequest && $past(s_q.ctlOne[`BIT_UPD_SRC]) |-> $past(counterOverflow))
        else $error("update request from non-overflow source");
    // software trigger requests when source and suppress clear
    AST_SW_REQ: assert property (@(posedge clk) disable iff (!rst_n)
        swTrig && s_q.ctlOne[2:1] == 2'b00 |=> updateIrqRequest)
        else $error("software update without request");
    AST_REINIT: assert property (@(posedge clk) disable iff (!rst_n)
        swTrig |=> counterReinit)
        else $error("software trigger did not reinit");
    // run bit clear gives no enable
    AST_RUN_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        !s_q.ctlOne[`BIT_RUN_EN] |=> !counterEnableSignal)
        else $error("counter enabled with run bit clear");
    AST_SINGLE: assert property (@(posedge clk) disable iff (!rst_n)
        s_d.updEvt && s_q.ctlOne[`BIT_SINGLE] |=> !s_q.ctlOne[`BIT_RUN_EN])
        else $error("single pulse did not stop");
    AST_TRIG_START: assert property (@(posedge clk) disable iff (!rst_n)
        sMode == SM_TRIGGER && trigSel && !s_q.ctlOne[`BIT_SINGLE] |=> s_q.ctlOne[0])
        else $error("trigger did not set run bit");
    AST_MM_UPDATE: assert property (@(posedge clk) disable iff (!rst_n)
        $past(mMode) == MM_UPDATE |-> triggerOutput == updateEvent)
        else $error("trigger output not update event");
    AST_MM_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
        mMode == MM_PULSE && channelOneEvent |=> triggerOutput)
        else $error("missing compare pulse");
    AST_IN_SEL: assert property (@(posedge clk) disable iff (!rst_n)
        !s_q.ctlTwo[`BIT_IN1_SEL] |=> filterInputOne == $past(captureInputOne))
        else $error("filter input not capture input");
    AST_MM_REF4: assert property (@(posedge clk) disable iff (!rst_n)
        mMode == MM_REF4 |=> triggerOutput == $past(refs.ref4))
        else $error("trigger output not ref four");
    AST_MM_REF1: assert property (@(posedge clk) disable iff (!rst_n)
        mMode == MM_REF1 |=> triggerOutput == $past(refs.ref1))
        else $error("trigger output not ref one");
    AST_MM_REF2: assert property (@(posedge clk) disable iff (!rst_n)
        mMode == MM_REF2 |=> triggerOutput == $past(refs.ref2))
        else $error("trigger output not ref two");
    AST_MM_REF3: assert property (@(posedge clk) disable iff (!rst_n)
        mMode == MM_REF3 |=> triggerOutput == $past(refs.ref3))
        else $error("trigger output not ref three");
    // software trigger reaches output one cycle after the update
    AST_MM_RESET_SW: assert property (@(posedge clk) disable iff (!rst_n)
        swTrig && mMode == MM_RESET |=> ##1 triggerOutput)
        else $error("software trigger missing on trigger output");
    AST_MM_RESET_SLAVE: assert property (@(posedge clk) disable iff (!rst_n)
        mMode == MM_RESET && slaveReset |=> triggerOutput)
        else $error("slave reset missing on trigger output");
    AST_MM_ENABLE: assert property (@(posedge clk) disable iff (!rst_n)
        mMode == MM_ENABLE |=> triggerOutput == counterEnableSignal)
        else $error("trigger output not counter enable");
    AST_GATE_NOSYNC: assert property (@(posedge clk) disable iff (!rst_n)
        sMode == SM_GATED && s_q.ctlOne[`BIT_RUN_EN] && !s_q.ctlOne[`BIT_MS_SYNC]
        |=> counterEnableSignal == $past(s_q.trigIn2))
        else $error("gated enable does not follow trigger");
    // sync bit adds a cycle to the gate
    AST_GATE_SYNC: assert property (@(posedge clk) disable iff (!rst_n)
        sMode == SM_GATED && s_q.ctlOne[`BIT_RUN_EN] && s_q.ctlOne[`BIT_MS_SYNC]
        |=> counterEnableSignal == $past(s_q.trigIn2, 2))
        else $error("synchronised gate not delayed");
    AST_SYNC_TRIG: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.ctlOne[`BIT_MS_SYNC] && sMode == SM_RESET && s_q.trigDly |=> counterReinit)
        else $error("delayed trigger lost");
    AST_HALL_SEL: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.ctlTwo[`BIT_IN1_SEL] |=> filterInputOne == $past(hallSensorInputs.hallA
        ^ hallSensorInputs.hallB ^ hallSensorInputs.hallC))
        else $error("filter input not hall xor");
    AST_SLAVE_REINIT: assert property (@(posedge clk) disable iff (!rst_n)
        slaveReset |=> counterReinit)
        else $error("slave reset did not reinit");
    AST_SUPP_NO_SHADOW: assert property (@(posedge clk) disable iff (!rst_n)
        $past(s_q.ctlOne[`BIT_UPD_SUPP]) |-> !shadowLoad)
        else $error("shadow load while suppressed");
    AST_SLAVE_REQ: assert property (@(posedge clk) disable iff (!rst_n)
        slaveReset && s_q.ctlOne[2:1] == 2'b00 |=> updateIrqRequest)
        else $error("slave update without request");
    AST_OVF_REQ: assert property (@(posedge clk) disable iff (!rst_n)
        counterOverflow && s_q.ctlOne[2:1] == 2'b10 |=> updateIrqRequest)
        else $error("overflow without request");
    AST_SW_UPDATE: assert property (@(posedge clk) disable iff (!rst_n)
        swTrig && !s_q.ctlOne[`BIT_UPD_SUPP] |=> updateEvent && shadowLoad)
        else $error("software trigger without update event");
    AST_RUN_ON: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.ctlOne[`BIT_RUN_EN] && sMode != SM_GATED |=> counterEnableSignal)
        else $error("counter stopped with run bit set");
    AST_MM_PULSE_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        mMode == MM_PULSE && !channelOneEvent |=> !triggerOutput)
        else $error("compare pulse without event");
    AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.irqStat[`IRQ_UPDATE] && s_q.irqMask[`IRQ_UPDATE] |-> irq)
        else $error("interrupt low with unmasked status");
endmodule : tmr_ctl

// File: tb/slave_timer_model.sv
// slave timer model that counts rising edges of the master trigger output
`timescale 1ns/1ps
module slave_timer_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic trg,
    output logic [7:0] edgeCount
);
    logic prevTrg_q;
    always @(posedge clk) begin
        if (!rst_n) begin
            prevTrg_q <= 1'b0;
            edgeCount <= 8'h00;
        end else begin
            prevTrg_q <= trg;
            if (trg && !prevTrg_q) begin
                edgeCount <= edgeCount + 8'h01;
            end
        end
    end
endmodule : slave_timer_model

// File: tb/test_timer_update_and_master_trigger.sv
// self-checking bench of the timer update and master trigger control block
`timescale 1ns/1ps
`include "tmr_ctl_regs.svh"
module test_timer_update_and_master_trigger
    import tmr_ctl_pkg::*;
;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err, clrSeen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic triggerInput, counterOverflow, channelOneEvent, captureInputOne;
    logic filterInputOne, counterEnableSignal, updateEvent, updateIrqRequest;
    logic shadowLoad, counterReinit, triggerOutput, irq;
    refs_s refs;
    hall_s hallSensorInputs;
    logic [4:0] seen;
    logic [7:0] edgeCount, startCount;
    logic [3:0] sel [4] = '{4'h8, 4'h2, 4'h4, 4'h1};
    int lat;
    int num_errors = 0;
    int checks = 0;
    tmr_ctl dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .triggerInput(triggerInput), .counterOverflow(counterOverflow),
        .channelOneEvent(channelOneEvent), .refs(refs), .captureInputOne(captureInputOne),
        .hallSensorInputs(hallSensorInputs), .filterInputOne(filterInputOne),
        .counterEnableSignal(counterEnableSignal), .updateEvent(updateEvent),
        .updateIrqRequest(updateIrqRequest), .shadowLoad(shadowLoad),
        .counterReinit(counterReinit), .triggerOutput(triggerOutput), .irq(irq));
    slave_timer_model slave (.clk(clk), .rst_n(rst_n), .trg(triggerOutput),
        .edgeCount(edgeCount));
    // sticky record of pulses, so their exact cycle need not be guessed
    always @(posedge clk) begin
        seen <= (clrSeen || !rst_n) ? 5'h00 : seen | {triggerOutput, counterReinit, shadowLoad,
            updateIrqRequest, updateEvent};
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string name, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // pready high ends this wait; only the watchdog ends a hang
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(name, rdata, e);
    endtask : rdc
    task automatic clearSeen;
        clrSeen <= 1'b1;
        @(posedge clk);
        clrSeen <= 1'b0;
    endtask : clearSeen
    task automatic settle(input logic [4:0] m, input logic [4:0] e, input string name);
        repeat (6) @(posedge clk);
        chk(name, 32'(seen & m), 32'(e));
        clearSeen();
    endtask : settle
    task automatic waitReinit(output int n);
        n = 0;
        triggerInput <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (counterReinit !== 1'b1 && n < 20);
        triggerInput <= 1'b0;
    endtask : waitReinit
    task automatic pulse(input logic ovf);
        counterOverflow <= ovf;
        channelOneEvent <= !ovf;
        @(posedge clk);
        counterOverflow <= 1'b0;
        channelOneEvent <= 1'b0;
        @(posedge clk);
    endtask : pulse
    task automatic results;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    initial begin
        #400000;
        num_errors++;
        results();
    end
    initial begin
        {rst_n, psel, penable, pwrite, triggerInput, counterOverflow} = 6'h00;
        {channelOneEvent, captureInputOne, clrSeen, paddr, pwdata} = '0;
        refs = '0;
        hallSensorInputs = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdc("ctl one", `CTL_ONE_OFFS, 32'h0000_0000);
        rdc("ctl two", `CTL_TWO_OFFS, 32'h0000_0000);
        rdc("unmapped", 12'h008, 32'h0000_0000);
        chk("slverr", 32'(err), 32'h0000_0001);
        for (int m = 4; m < 8; m++) begin
            apb(1'b1, `CTL_TWO_OFFS, {24'h0, 1'b0, 3'(m), 4'h0});
            refs <= refs_s'(sel[m - 4]);
            repeat (4) @(posedge clk);
            chk("ref on", 32'(triggerOutput), 32'h0000_0001);
            refs <= refs_s'(~sel[m - 4]);
            repeat (4) @(posedge clk);
            chk("ref off", 32'(triggerOutput), 32'h0000_0000);
        end
        captureInputOne <= 1'b1;
        apb(1'b1, `CTL_TWO_OFFS, 32'h0000_00FF);
        chk("ctl two mask", 32'(err), 32'h0000_0000);
        rdc("ctl two rb", `CTL_TWO_OFFS, 32'h0000_00F0);
        captureInputOne <= 1'b0;
        hallSensorInputs <= 3'h4;
        repeat (4) @(posedge clk);
        chk("hall xor", 32'(filterInputOne), 32'h0000_0001);
        hallSensorInputs <= 3'h6;
        repeat (4) @(posedge clk);
        chk("hall xor", 32'(filterInputOne), 32'h0000_0000);
        captureInputOne <= 1'b1;
        apb(1'b1, `CTL_TWO_OFFS, 32'h0000_0010);
        repeat (4) @(posedge clk);
        chk("capture in", 32'(filterInputOne), 32'h0000_0001);
        chk("enable low", 32'(triggerOutput), 32'h0000_0000);
        apb(1'b1, `CTL_ONE_OFFS, 32'h0000_0001);
        repeat (4) @(posedge clk);
        chk("enable high", 32'(counterEnableSignal), 32'h0000_0001);
        chk("enable trg", 32'(triggerOutput), 32'h0000_0001);
        apb(1'b1, `CTL_TWO_OFFS, 32'h0000_0020);
        clearSeen();
        settle(5'h1F, 5'h00, "idle");
        startCount = edgeCount;
        pulse(1'b1);
        settle(5'h17, 5'h17, "overflow");
        chk("slave count", 32'(edgeCount - startCount), 32'h0000_0001);
        apb(1'b1, `CTL_TWO_OFFS, 32'h0000_0030);
        startCount = edgeCount;
        pulse(1'b0);
        pulse(1'b0);
        @(posedge clk);
        chk("pulses", 32'(edgeCount - startCount), 32'h0000_0002);
        apb(1'b1, `CTL_TWO_OFFS, 32'h0000_0000);
        clearSeen();
        settle(5'h1F, 5'h00, "idle");
        apb(1'b1, `EVGEN_OFFS, 32'h0000_0001);
        settle(5'h17, 5'h17, "sw update");
        apb(1'b1, `CTL_ONE_OFFS, 32'h0000_0005);
        apb(1'b1, `EVGEN_OFFS, 32'h0000_0001);
        settle(5'h03, 5'h01, "source set");
        pulse(1'b1);
        settle(5'h03, 5'h03, "source ovf");
        apb(1'b1, `CTL_ONE_OFFS, 32'h0000_0003);
        apb(1'b1, `EVGEN_OFFS, 32'h0000_0001);
        settle(5'h0D, 5'h08, "suppressed");
        pulse(1'b1);
        settle(5'h05, 5'h00, "supp ovf");
        apb(1'b1, `CTL_ONE_OFFS, 32'h0000_0060);
        triggerInput <= 1'b1;
        repeat (8) @(posedge clk);
        rdc("trigger mode", `CTL_ONE_OFFS, 32'h0000_0061);
        triggerInput <= 1'b0;
        apb(1'b1, `CTL_ONE_OFFS, 32'h0000_0009);
        pulse(1'b1);
        rdc("single pulse", `CTL_ONE_OFFS, 32'h0000_0008);
        apb(1'b1, `CTL_TWO_OFFS, 32'h0000_0010);
        apb(1'b1, `CTL_ONE_OFFS, 32'h0000_0041);
        repeat (4) @(posedge clk);
        chk("gate shut", 32'(counterEnableSignal), 32'h0000_0000);
        triggerInput <= 1'b1;
        repeat (6) @(posedge clk);
        chk("gate open", 32'(counterEnableSignal), 32'h0000_0001);
        chk("gate trg", 32'(triggerOutput), 32'h0000_0001);
        triggerInput <= 1'b0;
        apb(1'b1, `CTL_TWO_OFFS, 32'h0000_0000);
        apb(1'b1, `CTL_ONE_OFFS, 32'h0000_0021);
        clearSeen();
        waitReinit(lat);
        chk("reset lag", 32'(lat), 32'h0000_0004);
        settle(5'h1F, 5'h1F, "slave reset");
        apb(1'b1, `CTL_ONE_OFFS, 32'h0000_0031);
        waitReinit(lat);
        chk("sync lag", 32'(lat), 32'h0000_0005);
        settle(5'h1F, 5'h1F, "sync reset");
        apb(1'b1, `CTL_ONE_OFFS, 32'h0000_0001);
        apb(1'b1, `IRQ_STAT_OFFS, 32'h0000_0003);
        rdc("stat clear", `IRQ_STAT_OFFS, 32'h0000_0000);
        apb(1'b1, `IRQ_MASK_OFFS, 32'h0000_0001);
        chk("irq idle", 32'(irq), 32'h0000_0000);
        pulse(1'b1);
        repeat (3) @(posedge clk);
        rdc("stat set", `IRQ_STAT_OFFS, 32'h0000_0001);
        chk("irq on", 32'(irq), 32'h0000_0001);
        apb(1'b1, `IRQ_MASK_OFFS, 32'h0000_0000);
        chk("irq masked", 32'(irq), 32'h0000_0000);
        apb(1'b1, `IRQ_STAT_OFFS, 32'h0000_0001);
        apb(1'b1, `IRQ_MASK_OFFS, 32'h0000_0001);
        chk("irq cleared", 32'(irq), 32'h0000_0000);
        results();
    end
endmodule : test_timer_update_and_master_trigger
